// [src/mdma_engine.sv]
// multichannel dma engine: per-channel fifos, arbiter, one master port
// assumes configuration held steady by surrounding logic; request lines asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "mdma_defines.svh"

module mdma_engine
	import mdma_pkg::*;
#(
	parameter int NCH = `MDMA_NCH
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rstn_i,
	input  wire logic                    ce_i,
	input  wire mdma_cfg_t [NCH-1:0]     cfg_i,
	input  wire logic [NCH-1:0]          src_req_i,
	input  wire logic [NCH-1:0]          dst_req_i,
	input  wire logic                    m_ack_i,
	input  wire logic [31:0]             m_rdata_i,
	output logic                         m_req_o,
	output logic                         m_we_o,
	output logic [1:0]                   m_size_o,
	output logic [`MDMA_ADDR_W-1:0]      m_addr_o,
	output logic [31:0]                  m_wdata_o,
	output logic [NCH-1:0]               done_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// R10 item width per transaction
	function automatic logic [2:0] item_bytes(input logic [1:0] w);
		item_bytes = (w == `MDMA_WID_8) ? 3'h1 : (w == `MDMA_WID_16) ? 3'h2 : 3'h4;
	endfunction

	function automatic logic [5:0] cap_bytes(input int ch);
		cap_bytes = (ch < `MDMA_BIG_CHANS) ? `MDMA_BIG_BYTES : `MDMA_SMALL_BYTES;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	mdma_state_t                        state_q;
	logic [3:0]                         gnt_q;
	logic [3:0]                         beats_q;
	logic [3:0]                         bcnt_q;
	logic                               m_req_q;
	logic                               m_we_q;
	logic [1:0]                         m_size_q;
	logic [`MDMA_ADDR_W-1:0]            m_addr_q;
	logic [31:0]                        m_wdata_q;
	logic [NCH-1:0]                     src_s1_q, src_s2_q, dst_s1_q, dst_s2_q;
	logic [NCH-1:0]                     done_q;
	logic [NCH-1:0][`MDMA_BLK_W-1:0]    rem_q;
	logic [NCH-1:0][`MDMA_ADDR_W-1:0]   src_q, dst_q;
	logic [NCH-1:0][2:0]                wp_q, rp_q;
	logic [NCH-1:0][5:0]                fill_q;
	logic [31:0]                        mem_q [NCH][`MDMA_FIFO_SLOTS];
	logic [NCH-1:0]                     elig;
	logic [3:0]                         pick;
	logic [3:0]                         pick_beats;
	logic [2:0]                         ib;

	assign ib = item_bytes(m_size_q);

	// ----------------------------------------
	// request synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			src_s1_q <= '0;
			src_s2_q <= '0;
			dst_s1_q <= '0;
			dst_s2_q <= '0;
		end else if (ce_i) begin
			src_s1_q <= src_req_i;
			src_s2_q <= src_s1_q;
			dst_s1_q <= dst_req_i;
			dst_s2_q <= dst_s1_q;
		end
	end

	// ----------------------------------------
	// arbiter: lowest eligible channel
	// ----------------------------------------
	always_comb begin
		logic [3:0] bl;
		logic [3:0] cl;
		logic [5:0] cw;
		cw         = 6'h01;
		pick       = 4'h0;
		pick_beats = 4'h1;
		bl         = 4'h1;
		cl         = 4'h1;
		for (int i = 0; i < NCH; i++) begin
			// R13 polarity per side
			elig[i] = cfg_i[i].en & ~done_q[i] & (rem_q[i] != `MDMA_BLK_RST)
				& (src_s2_q[i] ^ cfg_i[i].src_inv) & (dst_s2_q[i] ^ cfg_i[i].dst_inv);
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				pick = i[3:0];
			end
		end
		// R11 R9 burst length, large fifo only for eight
		bl = (cfg_i[pick].burst == `MDMA_BST_1) ? 4'h1 : (cfg_i[pick].burst == `MDMA_BST_4) ? 4'h4 : 4'h8;
		if (pick >= 4'(`MDMA_BIG_CHANS) && bl == 4'h8) begin
			bl = 4'h4;
		end
		// R15 R8 never more items than the fifo holds
		// clamp at full width, a 32-item capacity must not wrap to zero
		cw = cap_bytes(int'(pick)) / {3'h0, item_bytes(cfg_i[pick].width)};
		cl = (cw > 6'h08) ? 4'h8 : cw[3:0];
		pick_beats = (bl < cl) ? bl : cl;
		if ({8'h0, pick_beats} > rem_q[pick]) begin
			pick_beats = rem_q[pick][3:0];
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state_q   <= MDMA_S_IDLE;
			gnt_q     <= 4'h0;
			beats_q   <= 4'h0;
			bcnt_q    <= 4'h0;
			m_req_q   <= 1'b0;
			m_we_q    <= 1'b0;
			m_size_q  <= `MDMA_WID_8;
			m_addr_q  <= `MDMA_ADDR_RST;
			m_wdata_q <= 32'h0;
		end else if (ce_i) begin
			case (state_q)
				MDMA_S_IDLE: begin
					// R14 R1 grant one channel, start source read
					if (|elig) begin
						gnt_q    <= pick;
						beats_q  <= pick_beats;
						bcnt_q   <= 4'h0;
						m_req_q  <= 1'b1;
						m_we_q   <= 1'b0;
						m_size_q <= cfg_i[pick].width;
						m_addr_q <= src_q[pick];
						state_q  <= MDMA_S_RD;
					end
				end
				MDMA_S_RD: begin
					// R4 R5 read phase fills fifo, then switch to writes
					if (m_ack_i) begin
						bcnt_q   <= bcnt_q + 4'h1;
						m_addr_q <= m_addr_q + {29'h0, ib};
						if (bcnt_q + 4'h1 == beats_q) begin
							bcnt_q    <= 4'h0;
							m_we_q    <= 1'b1;
							m_addr_q  <= dst_q[gnt_q];
							m_wdata_q <= (beats_q == 4'h1) ? m_rdata_i : mem_q[gnt_q][rp_q[gnt_q]];
							state_q   <= MDMA_S_WR;
						end
					end
				end
				MDMA_S_WR: begin
					// R15 drain in fill order
					if (m_ack_i) begin
						bcnt_q    <= bcnt_q + 4'h1;
						m_addr_q  <= m_addr_q + {29'h0, ib};
						m_wdata_q <= mem_q[gnt_q][rp_q[gnt_q] + 3'h1];
						// R14 release after the last beat
						if (bcnt_q + 4'h1 == beats_q) begin
							m_req_q <= 1'b0;
							m_we_q  <= 1'b0;
							state_q <= MDMA_S_IDLE;
						end
					end
				end
				default: begin
					state_q <= MDMA_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// per-channel state and fifo
	// ----------------------------------------
	// R2 R3 one pairing per channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic ack_rd;
		logic ack_wr;
		assign ack_rd = (state_q == MDMA_S_RD) && m_ack_i && (gnt_q == 4'(c));
		assign ack_wr = (state_q == MDMA_S_WR) && m_ack_i && (gnt_q == 4'(c));

		always_ff @(posedge sys_clk_i) begin
			if (!rstn_i) begin
				rem_q[c]  <= `MDMA_BLK_RST;
				src_q[c]  <= `MDMA_ADDR_RST;
				dst_q[c]  <= `MDMA_ADDR_RST;
				done_q[c] <= 1'b0;
				wp_q[c]   <= 3'h0;
				rp_q[c]   <= 3'h0;
				fill_q[c] <= 6'h0;
			end else if (ce_i) begin
				if (!cfg_i[c].en) begin
					rem_q[c]  <= cfg_i[c].blk_size;
					src_q[c]  <= cfg_i[c].src_addr;
					dst_q[c]  <= cfg_i[c].dst_addr;
					done_q[c] <= 1'b0;
					wp_q[c]   <= 3'h0;
					rp_q[c]   <= 3'h0;
					fill_q[c] <= 6'h0;
				end else if (ack_rd) begin
					wp_q[c]   <= wp_q[c] + 3'h1;
					fill_q[c] <= fill_q[c] + {3'h0, ib};
					src_q[c]  <= src_q[c] + {29'h0, ib};
				end else if (ack_wr) begin
					rp_q[c]   <= rp_q[c] + 3'h1;
					fill_q[c] <= fill_q[c] - {3'h0, ib};
					dst_q[c]  <= dst_q[c] + {29'h0, ib};
					// R12 count down, stop at zero
					rem_q[c]  <= rem_q[c] - 12'h001;
					if (rem_q[c] == 12'h001) begin
						done_q[c] <= 1'b1;
					end
				end
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (ce_i && cfg_i[c].en && ack_rd) begin
				mem_q[c][wp_q[c]] <= m_rdata_i;
			end
		end
	end

	// R6 R7 single master port; configuration arrives apart on cfg_i
	assign m_req_o   = m_req_q;
	assign m_we_o    = m_we_q;
	assign m_size_o  = m_size_q;
	assign m_addr_o  = m_addr_q;
	assign m_wdata_o = m_wdata_q;
	assign done_o    = done_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_grant_held: assert property ((state_q != MDMA_S_IDLE) |=> $stable(gnt_q) || $past(state_q) == MDMA_S_WR) // R14
		else $error("grant changed mid transaction");
	a_grant_start: assert property ((ce_i && state_q == MDMA_S_IDLE && |elig) |=> (state_q == MDMA_S_RD && m_req_q && !m_we_q)) // R1
		else $error("eligible channel not served");
	a_read_first: assert property ($rose(m_we_q) |-> $past(state_q) == MDMA_S_RD) // R4
		else $error("write without preceding read");
	a_read_dir: assert property ((state_q == MDMA_S_RD) |-> !m_we_q && m_req_q) // R5
		else $error("read phase drives a write");
	a_fifo_bound: assert property (fill_q[gnt_q] <= cap_bytes(int'(gnt_q))) // R15
		else $error("fifo overfilled");
	a_drain_order: assert property ((state_q == MDMA_S_WR && m_ack_i && beats_q > 4'h1)
		|-> m_wdata_q == mem_q[gnt_q][rp_q[gnt_q]]) // R15
		else $error("fifo drained out of order");
	a_burst_len: assert property ((state_q != MDMA_S_IDLE) |-> beats_q inside {4'h1, 4'h2, 4'h4, 4'h8}
		&& (gnt_q < 4'(`MDMA_BIG_CHANS) || beats_q <= 4'h4)) // R11
		else $error("illegal burst length");
	a_size_legal: assert property (m_req_q |-> m_size_q != 2'h3) // R10
		else $error("illegal item width");
	a_block_stop: assert property ((ce_i && state_q == MDMA_S_WR && m_ack_i && rem_q[gnt_q] == 12'h001)
		|=> done_q[gnt_q] && state_q == MDMA_S_IDLE) // R12
		else $error("block did not stop on count");
	a_done_idle: assert property (done_q[gnt_q] |-> state_q == MDMA_S_IDLE) // R12
		else $error("finished channel still moving");

	c_single: cover property (state_q == MDMA_S_RD && beats_q == 4'h1 ##1 state_q == MDMA_S_WR);
	c_burst8: cover property (state_q == MDMA_S_WR && beats_q == 4'h8 && m_ack_i);
	c_done: cover property ($rose(done_q[0]));
	c_small_ch: cover property (state_q == MDMA_S_WR && gnt_q >= 4'h2 && m_ack_i);

endmodule

`default_nettype wire

// [src/mdma_defines.svh]
// constants for the multichannel dma engine: sizes, encodings, reset values
// assumes inclusion by bare name from the package and the engine
//
// Operation
// R1: on a channel request, read its source address, write its destination address
// R2: up to twelve independent channels, each serving one source/destination pair
// R3: one channel per distinct source and destination pairing
// R4: each transaction is a source-to-fifo read, then a fifo-to-destination write
// R5: one shared master port reads sources and writes destinations
// R6: no master port besides that single data-moving port
// R7: configuration reaches the engine apart from the master port
// R8: channels 0 and 1 hold 32 fifo bytes, all others 8 bytes
// R9: only the large-fifo channels may burst eight transactions
// R10: one transaction moves an 8, 16 or 32 bit item
// R11: a burst is 1, 4 or 8 single transactions; the engine also cuts bursts to 2 or to the items left
// R12: a block stops after exactly the programmed number of transactions
// R13: request lines active high by default, polarity invertible per side per channel
// R14: one channel owns the master port until its transaction finishes
// R15: fifo never overfills; writes drain in the same order reads filled it
`ifndef MDMA_DEFINES_SVH
`define MDMA_DEFINES_SVH

`define MDMA_NCH          12
`define MDMA_BIG_CHANS    2
`define MDMA_BIG_BYTES    6'h20
`define MDMA_SMALL_BYTES  6'h08
`define MDMA_FIFO_SLOTS   8
`define MDMA_ADDR_W       32
`define MDMA_BLK_W        12
`define MDMA_WID_8        2'h0
`define MDMA_WID_16       2'h1
`define MDMA_WID_32       2'h2
`define MDMA_BST_1        2'h0
`define MDMA_BST_4        2'h1
`define MDMA_BST_8        2'h2
`define MDMA_ADDR_RST     32'h0000_0000
`define MDMA_BLK_RST      12'h000

`endif

// [src/mdma_pkg.sv]
// types of the multichannel dma engine
// assumes mdma_defines.svh on the include path
`include "mdma_defines.svh"

package mdma_pkg;

	typedef struct packed {
		logic                     en;
		logic [`MDMA_ADDR_W-1:0]  src_addr;
		logic [`MDMA_ADDR_W-1:0]  dst_addr;
		logic [`MDMA_BLK_W-1:0]   blk_size;
		logic [1:0]               width;
		logic [1:0]               burst;
		logic                     src_inv;
		logic                     dst_inv;
	} mdma_cfg_t;

	// gray along idle -> read -> write
	typedef enum logic [1:0] {
		MDMA_S_IDLE = 2'h0,
		MDMA_S_RD   = 2'h1,
		MDMA_S_WR   = 2'h3
	} mdma_state_t;

endpackage

// [verif/mdma_bus_model.sv]
// bus partner: acks master beats after a set latency, read data derived from the address
// assumes engine holds each request until acked
`timescale 1ns/100ps
`default_nettype none

module mdma_bus_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic        m_req_i,
	input  wire logic [31:0] m_addr_i,
	output logic             m_ack_o,
	output logic [31:0]      m_rdata_o
);
	logic       fire;
	logic [3:0] cnt_q;

	assign fire = m_req_i && !m_ack_o && cnt_q >= lat_i;

	// one ack pulse per beat; data only valid with ack
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cnt_q <= 4'h0;
			m_ack_o <= 1'b0;
			m_rdata_o <= 32'h0;
		end else begin
			m_ack_o <= fire;
			cnt_q <= (m_req_i && !m_ack_o && !fire) ? cnt_q + 4'h1 : 4'h0;
			m_rdata_o <= fire ? (m_addr_i ^ 32'h5a5a_a5a5) : ~m_rdata_o;
		end
	end
endmodule

`default_nettype wire

// [verif/tb_mdma_engine.sv]
// testbench of the dma engine: beats logged at each ack and checked
// assumes mdma_pkg compiled and mdma_defines.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "mdma_defines.svh"

module tb_mdma_engine
	import mdma_pkg::*;
;
	logic                sys_clk = 1'b0;
	logic                rstn = 1'b0;
	logic                ce = 1'b1;
	mdma_cfg_t [11:0]    cfg = '0;
	logic [11:0]         sreq = 12'h0;
	logic [11:0]         dreq = 12'h0;
	logic [3:0]          lat = 4'h0;
	logic                m_ack, m_req, m_we;
	logic [1:0]          m_size;
	logic [31:0]         m_addr, m_wdata, m_rdata;
	logic [11:0]         done;
	logic                lw[$];
	logic [1:0]          ls[$];
	logic [31:0]         la[$], ld[$];
	int                  failures = 0;
	int                  checks = 0;

	always #10 sys_clk = ~sys_clk;

	mdma_engine dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(ce), .cfg_i(cfg), .src_req_i(sreq),
		.dst_req_i(dreq), .m_ack_i(m_ack), .m_rdata_i(m_rdata), .m_req_o(m_req), .m_we_o(m_we),
		.m_size_o(m_size), .m_addr_o(m_addr), .m_wdata_o(m_wdata), .done_o(done));
	mdma_bus_model bus (.sys_clk_i(sys_clk), .rstn_i(rstn), .lat_i(lat), .m_req_i(m_req),
		.m_addr_i(m_addr), .m_ack_o(m_ack), .m_rdata_o(m_rdata));

	always @(posedge sys_clk) begin
		if (m_req && m_ack) begin
			lw.push_back(m_we);
			ls.push_back(m_size);
			la.push_back(m_addr);
			ld.push_back(m_wdata);
		end
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic arm(input int ch, input logic [1:0] w, input logic [1:0] b, input int n, input logic inv);
		cfg[ch].src_addr = 32'h1000_0000 + (ch << 12);
		cfg[ch].dst_addr = 32'h2000_0000 + (ch << 12);
		cfg[ch].blk_size = n[11:0];
		cfg[ch].width = w;
		cfg[ch].burst = b;
		cfg[ch].src_inv = inv;
		cfg[ch].dst_inv = inv;
		cyc(1);
		cfg[ch].en = 1'b1;
		sreq[ch] = !inv;
		dreq[ch] = !inv;
	endtask

	task automatic wait_done(input int ch);
		for (int i = 0; i < 3000 && done[ch] !== 1'b1; i++)
			cyc(1);
		cyc(6);
	endtask

	task automatic idle(input int ch);
		cfg[ch] = '0;
		sreq[ch] = 1'b0;
		dreq[ch] = 1'b0;
		cyc(2);
	endtask

	// one block on one channel, nb items per grant
	task automatic go(input int ch, input logic [1:0] w, input logic [1:0] b, input int n, input int nb,
		input logic inv);
		int by, g, k, it;
		logic [31:0] ra, mk;
		by = 1 << w;
		mk = (w == `MDMA_WID_32) ? 32'hffff_ffff : (32'h1 << (8 * by)) - 32'h1;
		lw.delete(); ls.delete(); la.delete(); ld.delete();
		arm(ch, w, b, n, inv);
		wait_done(ch);
		chk(done[ch], 1'b1);
		chk(la.size(), 2 * n);
		for (int j = 0; j < la.size() && j < 2 * n; j++) begin
			g = j / (2 * nb);
			k = j % (2 * nb);
			it = g * nb + ((k < nb) ? k : k - nb);
			ra = cfg[ch].src_addr + it * by;
			chk(lw[j], k >= nb);
			chk(ls[j], w);
			chk(la[j], (k < nb) ? ra : cfg[ch].dst_addr + it * by);
			if (k >= nb)
				chk(ld[j] & mk, (ra ^ 32'h5a5a_a5a5) & mk);
		end
		idle(ch);
	endtask

	task automatic s_single();
		lat = 4'h0;
		go(5, `MDMA_WID_32, `MDMA_BST_1, 3, 1, 1'b0);
	endtask

	task automatic s_small_fifo();
		lat = 4'h2;
		go(5, `MDMA_WID_32, `MDMA_BST_8, 4, 2, 1'b0);
		go(6, `MDMA_WID_16, `MDMA_BST_4, 8, 4, 1'b0);
		go(7, `MDMA_WID_8, `MDMA_BST_8, 8, 4, 1'b0);
	endtask

	task automatic s_big_fifo();
		lat = 4'h1;
		go(0, `MDMA_WID_8, `MDMA_BST_8, 16, 8, 1'b0);
		go(1, `MDMA_WID_32, `MDMA_BST_8, 8, 8, 1'b1);
	endtask

	task automatic s_polarity();
		la.delete();
		// source line held inactive long enough to pass the synchroniser
		sreq[2] = 1'b1;
		cfg[2].src_addr = 32'h1000_2000;
		cfg[2].dst_addr = 32'h2000_2000;
		cfg[2].blk_size = 12'h001;
		cfg[2].width = `MDMA_WID_32;
		cfg[2].src_inv = 1'b1;
		cfg[2].dst_inv = 1'b1;
		cyc(3);
		cfg[2].en = 1'b1;
		cyc(30);
		chk(la.size(), 0);
		chk(done[2], 1'b0);
		sreq[2] = 1'b0;
		wait_done(2);
		chk(la.size(), 2);
		idle(2);
	endtask

	task automatic s_priority();
		lat = 4'h0;
		la.delete(); lw.delete();
		cfg[3].src_addr = 32'h1000_3000;
		cfg[3].dst_addr = 32'h2000_3000;
		cfg[3].blk_size = 12'h002;
		cfg[3].width = `MDMA_WID_32;
		arm(11, `MDMA_WID_32, `MDMA_BST_1, 2, 1'b0);
		cfg[3].en = 1'b1;
		sreq[3] = 1'b1;
		dreq[3] = 1'b1;
		wait_done(11);
		chk(done[3], 1'b1);
		chk(la.size(), 8);
		for (int j = 0; j < la.size() && j < 8; j++) begin
			chk(lw[j], j % 2);
			if (j % 2 == 0)
				chk(la[j], ((j < 4) ? 32'h1000_3000 : 32'h1000_b000) + (j % 4) * 2);
		end
		idle(3);
		idle(11);
	endtask

	// clock enable low mid-request: outputs frozen, transfer resumes
	task automatic s_freeze();
		logic [31:0] a0;
		lat = 4'hf;
		la.delete();
		arm(4, `MDMA_WID_32, `MDMA_BST_1, 1, 1'b0);
		for (int i = 0; i < 10 && m_req !== 1'b1; i++)
			cyc(1);
		a0 = m_addr;
		ce = 1'b0;
		cyc(4);
		chk(m_req, 1'b1);
		chk(m_addr, a0);
		chk(a0, 32'h1000_4000);
		ce = 1'b1;
		lat = 4'h0;
		wait_done(4);
		chk(la.size(), 2);
		idle(4);
	endtask

	initial begin
		cyc(10);
		rstn = 1'b1;
		cyc(1);
		chk(m_req, 1'b0);
		chk(done, 12'h0);
		s_single();
		s_small_fifo();
		s_big_fifo();
		s_polarity();
		s_priority();
		s_freeze();
		summarize();
	end

	initial begin
		#(20 * 20000);
		failures++;
		summarize();
	end
endmodule

`default_nettype wire
